//--- src/irem_pkg.sv
package irem_pkg;
  // register indices on the control port
  localparam logic [7:0] ADDR_FLOOR_RISE = 8'h0A;
  localparam logic [7:0] ADDR_SILENCE_RISE = 8'h0B;
  localparam logic [7:0] ADDR_RAMP_RISE = 8'h0C;
  localparam logic [7:0] ADDR_MISC_RISE = 8'h0D;
  localparam logic [7:0] ADDR_FLOOR_FALL = 8'h0F;
  localparam logic [7:0] ADDR_SILENCE_FALL = 8'h10;
  localparam logic [7:0] ADDR_RAMP_FALL = 8'h11;
  localparam logic [7:0] ADDR_MISC_FALL = 8'h12;
  localparam logic [7:0] ADDR_FLOOR_CLR = 8'h14;
  localparam logic [7:0] ADDR_SILENCE_CLR = 8'h15;
  localparam logic [7:0] ADDR_RAMP_CLR = 8'h16;
  localparam logic [7:0] ADDR_MISC_CLR = 8'h17;
  localparam logic [7:0] ADDR_FLOOR_SRC = 8'hEA;
  localparam logic [7:0] ADDR_SILENCE_SRC = 8'hEB;
  localparam logic [7:0] ADDR_RAMP_SRC = 8'hEC;
  localparam logic [7:0] ADDR_MISC_SRC = 8'hED;
  // reset value and misc field layout
  localparam logic [7:0] MASK_RESET = 8'h00;
  localparam logic [7:0] MISC_USED = 8'hE3; // bits 4:2 reserved
  localparam int NUM_GROUPS = 4;
endpackage

//--- src/irem_top.sv
// Notes on behaviour
// - rise mask bit one: a low-to-high flag change becomes a pending interrupt
// - rise mask bit zero: a low-to-high flag change is ignored
// - volume-floor rise masks: bit 7 is channel 8, bit 0 channel 1, reset zero
// - automute rise masks: channel 8 at bit 7, channel 1 at bit 0, reset zero
// - full-ramp rise masks: channel 8 at bit 7, channel 1 at bit 0, reset zero
// - misc rise: override mask bits 7:6, frame valid bit 5, 4:2 reserved
// - misc rise: clock-loss mask bit 1, packed-dsd mask bit 0, reset zero
// - separate fall masks: zero ignores high-to-low change, one services it
// - writing one to a clear bit clears that pending interrupt
module irem_top (
  input wire logic CLK,
  input wire logic SYS_RST,
  input wire logic REG_WE,
  input wire logic REG_RE,
  input wire logic [7:0] REG_ADDR,
  input wire logic [7:0] REG_WDATA,
  input wire logic [7:0] FLOOR_FLAGS,
  input wire logic [7:0] SILENCE_FLAGS,
  input wire logic [7:0] RAMP_DONE_FLAGS,
  input wire logic [7:0] MISC_FLAGS,
  output logic [7:0] REG_RDATA,
  output logic REG_RVALID,
  output logic IRQ
);

  // group 0 floor, 1 silence (automute), 2 ramp done, 3 misc
  logic [7:0] rise_en_ff [4];
  logic [7:0] fall_en_ff [4];
  logic [7:0] pend_ff [4];
  logic [7:0] flag_prev_ff [4];

  // flag view per group and the bits that exist in it
  logic [7:0] flags [4];
  logic [7:0] used [4];

  // registered outputs
  logic [7:0] rdata_ff;
  logic rvalid_ff;
  logic irq_ff;

  // per-group summaries feeding the output stage
  logic [3:0] any_pend;
  logic [7:0] rd_term [4];

  // named enable bits of the volume-floor field
  wire [7:0] floor_rise_en = rise_en_ff[0];
  wire floor_ch1_rise_en = floor_rise_en[0];
  wire floor_ch8_rise_en = floor_rise_en[7];

  // named enable bits of the automute field
  wire silence_ch1_rise_en = rise_en_ff[1][0];
  wire silence_ch8_rise_en = rise_en_ff[1][7];

  // named enable bits of the full-ramp field
  wire ramp_done_ch1_rise_en = rise_en_ff[2][0];
  wire ramp_done_ch8_rise_en = rise_en_ff[2][7];

  // named fields of the misc rise register
  wire [1:0] source_override_rise_en = rise_en_ff[3][7:6];
  wire frame_valid_rise_en = rise_en_ff[3][5];
  wire link_clock_loss_rise_en = rise_en_ff[3][1];
  wire packed_dsd_rise_en = rise_en_ff[3][0];

  // first fall enable, kept for symmetry with the rise side
  wire floor_ch1_fall_en = fall_en_ff[0][0];

  // misc rise readback rebuilt from its named fields
  wire [7:0] misc_rise_view = {
    source_override_rise_en,
    frame_valid_rise_en,
    3'h0,
    link_clock_loss_rise_en,
    packed_dsd_rise_en
  };

  // readback view of each rise mask register
  logic [7:0] rise_view [4];
  assign rise_view[0] = floor_rise_en;
  assign rise_view[1] = rise_en_ff[1];
  assign rise_view[2] = rise_en_ff[2];
  assign rise_view[3] = misc_rise_view;

  // source flags per group; misc reserved bits never set
  assign flags[0] = FLOOR_FLAGS;
  assign flags[1] = SILENCE_FLAGS;
  assign flags[2] = RAMP_DONE_FLAGS;
  assign flags[3] = MISC_FLAGS & irem_pkg::MISC_USED;

  // bits that exist in each group
  assign used[0] = 8'hFF;
  assign used[1] = 8'hFF;
  assign used[2] = 8'hFF;
  assign used[3] = irem_pkg::MISC_USED;

  // rise mask register indices
  wire [7:0] rise_addr [4] = '{
    irem_pkg::ADDR_FLOOR_RISE,
    irem_pkg::ADDR_SILENCE_RISE,
    irem_pkg::ADDR_RAMP_RISE,
    irem_pkg::ADDR_MISC_RISE
  };

  // fall mask register indices
  wire [7:0] fall_addr [4] = '{
    irem_pkg::ADDR_FLOOR_FALL,
    irem_pkg::ADDR_SILENCE_FALL,
    irem_pkg::ADDR_RAMP_FALL,
    irem_pkg::ADDR_MISC_FALL
  };

  // clear register indices, write-only, read as zero
  wire [7:0] clr_addr [4] = '{
    irem_pkg::ADDR_FLOOR_CLR,
    irem_pkg::ADDR_SILENCE_CLR,
    irem_pkg::ADDR_RAMP_CLR,
    irem_pkg::ADDR_MISC_CLR
  };

  // pending readback indices
  wire [7:0] src_addr [4] = '{
    irem_pkg::ADDR_FLOOR_SRC,
    irem_pkg::ADDR_SILENCE_SRC,
    irem_pkg::ADDR_RAMP_SRC,
    irem_pkg::ADDR_MISC_SRC
  };

  // one slice per group: decode, edges, masks and pending bits
  genvar g;
  generate
    for (g = 0; g < irem_pkg::NUM_GROUPS; g++) begin : grp
      // write strobes of this group's registers
      wire wr_rise = REG_WE && (REG_ADDR == rise_addr[g]);
      wire wr_fall = REG_WE && (REG_ADDR == fall_addr[g]);
      wire wr_clr = REG_WE && (REG_ADDR == clr_addr[g]);

      // read selects of this group's registers
      wire sel_rise = (REG_ADDR == rise_addr[g]);
      wire sel_fall = (REG_ADDR == fall_addr[g]);
      wire sel_src = (REG_ADDR == src_addr[g]);

      // edge detection against the previous sample
      wire [7:0] rose = flags[g] & ~flag_prev_ff[g];
      wire [7:0] fell = ~flags[g] & flag_prev_ff[g] & used[g];

      // masks decide which edges are serviced
      wire [7:0] hit_rise = rose & rise_en_ff[g];
      wire [7:0] hit_fall = fell & fall_en_ff[g];

      // clear bits only count during a clear write
      wire [7:0] clr = wr_clr ? REG_WDATA : 8'h00;

      // new edges win over a same-cycle clear
      wire [7:0] nxt_pend =
        (pend_ff[g] & ~clr) |
        hit_rise |
        hit_fall;

      // any pending bit in this group
      assign any_pend[g] = |pend_ff[g];

      // read data term; other indices give zero
      assign rd_term[g] =
        (sel_rise ? rise_view[g] : 8'h00) |
        (sel_fall ? fall_en_ff[g] : 8'h00) |
        (sel_src ? pend_ff[g] : 8'h00);

      // mask registers, reserved bits held at zero
      always_ff @(posedge CLK) begin
        if (SYS_RST) begin
          rise_en_ff[g] <= irem_pkg::MASK_RESET;
          fall_en_ff[g] <= irem_pkg::MASK_RESET;
        end else begin
          if (wr_rise) begin
            rise_en_ff[g] <= REG_WDATA & used[g];
          end
          if (wr_fall) begin
            fall_en_ff[g] <= REG_WDATA & used[g];
          end
        end
      end

      // pending flags and previous flag sample
      always_ff @(posedge CLK) begin
        if (SYS_RST) begin
          pend_ff[g] <= irem_pkg::MASK_RESET;
          flag_prev_ff[g] <= irem_pkg::MASK_RESET;
        end else begin
          pend_ff[g] <= nxt_pend;
          flag_prev_ff[g] <= flags[g];
        end
      end
    end
  endgenerate

  // or of the per-group read terms
  wire [7:0] nxt_rdata =
    rd_term[0] |
    rd_term[1] |
    rd_term[2] |
    rd_term[3];

  // any group pending raises the interrupt
  wire nxt_irq = |any_pend;

  // read data, valid strobe and interrupt output
  // read data is zero outside the valid cycle
  always_ff @(posedge CLK) begin
    if (SYS_RST) begin
      rdata_ff <= irem_pkg::MASK_RESET;
      rvalid_ff <= 1'b0;
      irq_ff <= 1'b0;
    end else begin
      rdata_ff <= REG_RE ? nxt_rdata : 8'h00;
      rvalid_ff <= REG_RE;
      irq_ff <= nxt_irq;
    end
  end

  // ports come straight from the output flops
  assign REG_RDATA = rdata_ff;
  assign REG_RVALID = rvalid_ff;
  assign IRQ = irq_ff;
endmodule

//--- test/irem_assertions.sv
module irem_assertions (
  input wire logic CLK,
  input wire logic SYS_RST,
  input wire logic REG_WE,
  input wire logic REG_RE,
  input wire logic [7:0] REG_ADDR,
  input wire logic [7:0] REG_RDATA,
  input wire logic REG_RVALID,
  input wire logic IRQ
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge CLK); endclocking
  default disable iff (SYS_RST);
  // read timing, reset state and interrupt level
  a_rv_after_re: assert property (REG_RE |=> REG_RVALID)
    else $error("rvalid missing");
  a_rv_has_re: assert property (REG_RVALID |-> $past(REG_RE))
    else $error("rvalid stray");
  a_rd_idle: assert property (!REG_RVALID |-> REG_RDATA == 8'h00)
    else $error("rdata not idle");
  a_hole_zero: assert property (REG_RE && REG_ADDR == 8'h0E |=> !REG_RDATA)
    else $error("hole read");
  a_resv_zero: assert property (REG_RE && REG_ADDR[3:0] == 4'hD |=>
    REG_RDATA[4:2] == 3'h0) else $error("reserved bits");
  a_rst_quiet: assert property ($fell(SYS_RST) |-> !IRQ && !REG_RVALID)
    else $error("reset state");
  a_irq_holds: assert property (IRQ && !REG_WE && !$past(REG_WE) |=> IRQ)
    else $error("irq dropped");
  a_irq_fall: assert property ($fell(IRQ) |-> $past(REG_WE, 2))
    else $error("irq fell alone");
endmodule
bind irem_top irem_assertions u_chk (.CLK(CLK), .SYS_RST(SYS_RST),
  .REG_WE(REG_WE), .REG_RE(REG_RE), .REG_ADDR(REG_ADDR),
  .REG_RDATA(REG_RDATA), .REG_RVALID(REG_RVALID), .IRQ(IRQ));

//--- test/irem_flag_src.sv
module irem_flag_src (
  input wire logic CLK,
  input wire logic [31:0] want,
  output logic [31:0] flags
);
  timeunit 1ns;
  timeprecision 1ps;
  // status lines change on the clock like the real sources
  always_ff @(posedge CLK) begin
    flags <= want;
  end
endmodule

//--- test/tb_interrupt_rise_edge_masking.sv
module tb_interrupt_rise_edge_masking;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'h0, rst = 1'h1, we = 1'h0, re = 1'h0, rv, irq;
  logic [7:0] a = 8'h00, d = 8'h00, q, ev;
  logic [31:0] want = 32'h0, fl;
  int n_fail = 0, comparisons = 0;
  // clock, status source and device
  always #2 clk = ~clk;
  irem_flag_src u_src (.CLK(clk), .want(want), .flags(fl));
  irem_top uut (.CLK(clk), .SYS_RST(rst), .REG_WE(we), .REG_RE(re),
    .REG_ADDR(a), .REG_WDATA(d), .FLOOR_FLAGS(fl[7:0]),
    .SILENCE_FLAGS(fl[15:8]), .RAMP_DONE_FLAGS(fl[23:16]),
    .MISC_FLAGS(fl[31:24]), .REG_RDATA(q), .REG_RVALID(rv), .IRQ(irq));
  task automatic chk(logic [7:0] got, logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] %0t got %h want %h", $time, got, exp);
    end
  endtask
  task automatic wr(logic [7:0] ad, logic [7:0] dv);
    @(posedge clk);
    we <= 1'h1;
    a <= ad;
    d <= dv;
    @(posedge clk);
    we <= 1'h0;
  endtask
  task automatic rd(logic [7:0] ad, logic [7:0] exp);
    @(posedge clk);
    re <= 1'h1;
    a <= ad;
    @(posedge clk);
    re <= 1'h0;
    #1;
    chk(q, exp);
  endtask
  task automatic summarize();
    $display("comparisons %0d n_fail %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  // limit far beyond the expected run
  initial begin
    #8000;
    n_fail++;
    summarize();
  end
  // masks, edges, clears and holes
  initial begin
    repeat (4) @(posedge clk);
    rst <= 1'h0;
    rd(irem_pkg::ADDR_FLOOR_FALL, 8'h00);
    for (int i = 0; i < 4; i++) begin
      ev = (i == 3) ? 8'hA1 : 8'hA5;
      rd(irem_pkg::ADDR_FLOOR_RISE + 8'(i), 8'h00);
      wr(irem_pkg::ADDR_FLOOR_RISE + 8'(i), 8'hA5);
      rd(irem_pkg::ADDR_FLOOR_RISE + 8'(i), ev);
    end
    @(posedge clk);
    want <= 32'hFFFFFFFF;
    repeat (4) @(posedge clk);
    #1 chk({7'h00, irq}, 8'h01);
    for (int i = 0; i < 4; i++) begin
      ev = (i == 3) ? 8'hA1 : 8'hA5;
      rd(irem_pkg::ADDR_FLOOR_SRC + 8'(i), ev);
      wr(irem_pkg::ADDR_FLOOR_CLR + 8'(i), 8'hFF);
      rd(irem_pkg::ADDR_FLOOR_SRC + 8'(i), 8'h00);
    end
    chk({7'h00, irq}, 8'h00);
    wr(irem_pkg::ADDR_FLOOR_FALL, 8'h0F);
    @(posedge clk);
    want <= 32'h0;
    repeat (4) @(posedge clk);
    rd(irem_pkg::ADDR_FLOOR_SRC, 8'h0F);
    rd(irem_pkg::ADDR_SILENCE_SRC, 8'h00);
    rd(8'h0E, 8'h00);
    summarize();
  end
endmodule
